// [verilog/spims_pkg.sv]
package spims_pkg;
  // ---------------------------------------------
  // register indices, byte address is index * 4
  // ---------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;
  localparam logic [7:0] IDX_DATA = 8'h12;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int C_RXIE = 7;
  localparam int C_MSTR = 5;
  localparam int C_CLOCK_POLARITY_BIT = 4;
  localparam int C_CLOCK_PHASE_BIT = 3;
  localparam int C_SPE = 1;
  localparam int C_TXIE = 0;
  localparam int S_RXF = 7;
  localparam int S_OVR = 6;
  localparam int S_TXE = 3;
  // ---------------------------------------------
  // reset values and counts
  // ---------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------
  // transfer states
  // ---------------------------------------------
  typedef enum logic [0:0] {
    SPIMS_IDLE = 1'b0,
    SPIMS_RUN = 1'b1
  } spims_state_type;
  function automatic logic [6:0] half_cycles(input logic [1:0] rate);
    case (rate)
      2'h0: half_cycles = HALF_DIV2;
      2'h1: half_cycles = HALF_DIV8;
      2'h2: half_cycles = HALF_DIV32;
      default: half_cycles = HALF_DIV128;
    endcase
  endfunction : half_cycles
endpackage : spims_pkg

// [verilog/spims_core.sv]
// Our own choice: register access over AXI4-Lite.
module spims_core
  import spims_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic ss_n_in,
  // interrupt requests
  output logic irq_rx_full,
  output logic irq_tx_empty
);
  // ---------------------------------------------
  // declarations
  // ---------------------------------------------
  spims_state_type state_q;
  logic [7:0] ctrl_q;
  logic [1:0] rate_q;
  logic [7:0] txsh_q, rxsh_q, txbuf_q, hold_q, rx_data_q;
  logic rxf_q, ovr_q, txe_q, arm_q;
  logic [4:0] edge_q;
  logic [6:0] div_q;
  logic sclk_q;
  logic [2:0] sck_s_q, ss_s_q, mosi_s_q, miso_s_q;
  logic sck_f_q, ss_f_q, mosi_f_q, miso_f_q;
  logic sck_d_q, ss_d_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic sclk_oe_n_q, mosi_oe_n_q, miso_oe_n_q, irq_rx_q, irq_tx_q;
  logic mstr, module_enable_bit, clock_phase_bit, clock_polarity_bit, m_on;
  logic wr_go, rd_go, wr_dr, wr_cr, wr_sr, rd_dr, rd_sr;
  logic [7:0] wr_byte, wr_idx, rd_idx;
  logic s_sel, s_chg, s_lead, s_trail, ss_fall, s_start;
  logic m_tick, lead, trail, ev, smp, shf, done, abort, din;
  logic load_now, m_start, clr;
  logic [7:0] rx_byte;

  // ---------------------------------------------
  // control decode
  // ---------------------------------------------
  assign mstr = ctrl_q[C_MSTR];
  assign module_enable_bit = ctrl_q[C_SPE];
  assign clock_phase_bit = ctrl_q[C_CLOCK_PHASE_BIT];
  assign clock_polarity_bit = ctrl_q[C_CLOCK_POLARITY_BIT];
  assign m_on = mstr & module_enable_bit;
  assign wr_idx = s_axi_awaddr[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_go = awready_q & s_axi_awvalid & wready_q & s_axi_wvalid;
  assign rd_go = arready_q & s_axi_arvalid;
  assign wr_dr = wr_go & s_axi_wstrb[0] & (wr_idx == IDX_DATA);
  assign wr_cr = wr_go & s_axi_wstrb[0] & (wr_idx == IDX_CONTROL);
  assign wr_sr = wr_go & s_axi_wstrb[0] & (wr_idx == IDX_STATUS);
  assign rd_dr = rd_go & (rd_idx == IDX_DATA);
  assign rd_sr = rd_go & (rd_idx == IDX_STATUS);

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {sck_s_q, mosi_s_q, miso_s_q} <= 9'h000;
      {sck_f_q, mosi_f_q, miso_f_q, sck_d_q} <= 4'h0;
      {ss_s_q, ss_f_q, ss_d_q} <= 5'h1f;
    end
    else if (ce)
    begin
      sck_s_q <= {sck_s_q[1:0], sclk_in};
      ss_s_q <= {ss_s_q[1:0], ss_n_in};
      mosi_s_q <= {mosi_s_q[1:0], mosi_in};
      miso_s_q <= {miso_s_q[1:0], miso_in};
      if (sck_s_q[1] == sck_s_q[2])
        sck_f_q <= sck_s_q[2];
      if (ss_s_q[1] == ss_s_q[2])
        ss_f_q <= ss_s_q[2];
      if (mosi_s_q[1] == mosi_s_q[2])
        mosi_f_q <= mosi_s_q[2];
      if (miso_s_q[1] == miso_s_q[2])
        miso_f_q <= miso_s_q[2];
      sck_d_q <= sck_f_q;
      ss_d_q <= ss_f_q;
    end
  end

  // ---------------------------------------------
  // edge events
  // ---------------------------------------------
  always_comb
  begin
    s_sel = module_enable_bit & ~mstr & ~ss_f_q;
    s_chg = sck_f_q ^ sck_d_q;
    s_lead = s_sel & s_chg & (sck_f_q != clock_polarity_bit);
    s_trail = s_sel & s_chg & (sck_f_q == clock_polarity_bit);
    ss_fall = ss_d_q & ~ss_f_q;
    s_start = 1'b0;
    if (!mstr && module_enable_bit && state_q == SPIMS_IDLE)
      s_start = clock_phase_bit ? s_lead : (ss_fall & s_sel);
    m_tick = m_on & (state_q == SPIMS_RUN) & (div_q == 7'h00);
    lead = mstr ? (m_tick & (sclk_q == clock_polarity_bit)) : s_lead;
    trail = mstr ? (m_tick & (sclk_q != clock_polarity_bit)) : s_trail;
    ev = ((state_q == SPIMS_RUN) | s_start) & (lead | trail);
    smp = ev & (clock_phase_bit ? trail : lead);
    shf = ev & (clock_phase_bit ? (lead & (edge_q != 5'h00)) : trail);
    done = ev & (edge_q == EDGES_PER_BYTE - 5'h01);
    abort = (state_q == SPIMS_RUN) & (~module_enable_bit | (~mstr & ss_f_q));
    din = mstr ? miso_f_q : mosi_f_q;
    rx_byte = smp ? {rxsh_q[6:0], din} : rxsh_q;
    load_now = wr_dr & (state_q == SPIMS_IDLE) & ~s_start;
    m_start = wr_dr & m_on & (state_q == SPIMS_IDLE);
    clr = rd_dr & arm_q;
  end

  // ---------------------------------------------
  // transfer sequencing
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SPIMS_IDLE;
      {edge_q, div_q, sclk_q} <= 13'h0000;
    end
    else if (ce)
    begin
      case (state_q)
        SPIMS_IDLE:
        begin
          if (m_start || s_start)
            state_q <= SPIMS_RUN;
        end
        SPIMS_RUN:
        begin
          if (abort)
            state_q <= SPIMS_IDLE;
          else if (done && !(m_on && !txe_q))
            state_q <= SPIMS_IDLE;
        end
        default:
          state_q <= SPIMS_IDLE;
      endcase
      if (abort || done)
        edge_q <= 5'h00;
      else if (ev)
        edge_q <= edge_q + 5'h01;
      if (m_start || m_tick)
        div_q <= half_cycles(rate_q) - 7'h01;
      else if (div_q != 7'h00)
        div_q <= div_q - 7'h01;
      if (state_q != SPIMS_RUN || !m_on)
        sclk_q <= clock_polarity_bit;
      else if (m_tick)
        sclk_q <= ~sclk_q;
    end
  end

  // ---------------------------------------------
  // shift registers and transmit buffer
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {txsh_q, rxsh_q, hold_q, txbuf_q} <= {4{BYTE_RST}};
      txe_q <= 1'b1;
    end
    else if (ce)
    begin
      if (load_now)
      begin
        txsh_q <= wr_byte;
        hold_q <= wr_byte;
      end
      else if (done && !txe_q)
      begin
        txsh_q <= txbuf_q;
        hold_q <= txbuf_q;
      end
      else if (done || abort)
        txsh_q <= hold_q;
      else if (shf)
        txsh_q <= {txsh_q[6:0], 1'b0};
      if (abort || done)
        rxsh_q <= BYTE_RST;
      else if (smp)
        rxsh_q <= {rxsh_q[6:0], din};
      if (wr_dr && !load_now)
        txbuf_q <= wr_byte;
      if (load_now)
        txe_q <= 1'b1;
      else if (wr_dr)
        txe_q <= 1'b0;
      else if (done)
        txe_q <= 1'b1;
    end
  end

  // ---------------------------------------------
  // receive register and flags
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data_q <= BYTE_RST;
      {rxf_q, ovr_q, arm_q} <= 3'h0;
    end
    else if (ce)
    begin
      if (rd_sr)
        arm_q <= rxf_q | ovr_q;
      else if (rd_dr)
        arm_q <= 1'b0;
      if (done && rxf_q && !clr)
        ovr_q <= 1'b1;
      else if (clr)
        ovr_q <= 1'b0;
      if (done && !(rxf_q && !clr))
      begin
        rx_data_q <= rx_byte;
        rxf_q <= 1'b1;
      end
      else if (clr)
        rxf_q <= 1'b0;
    end
  end

  // ---------------------------------------------
  // control registers
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      rate_q <= RATE_RST;
    end
    else if (ce)
    begin
      if (wr_cr)
        ctrl_q <= wr_byte;
      else if (wr_dr)
        ctrl_q[C_TXIE] <= 1'b0;
      if (wr_sr)
        rate_q <= wr_byte[1:0];
    end
  end

  // ---------------------------------------------
  // pin drivers and interrupt requests
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {sclk_oe_n_q, mosi_oe_n_q, miso_oe_n_q} <= 3'h7;
      {irq_rx_q, irq_tx_q} <= 2'h0;
    end
    else if (ce)
    begin
      sclk_oe_n_q <= ~m_on;
      mosi_oe_n_q <= ~m_on;
      miso_oe_n_q <= ~s_sel;
      irq_rx_q <= rxf_q & ctrl_q[C_RXIE];
      irq_tx_q <= txe_q & ctrl_q[C_TXIE];
    end
  end

  // ---------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {awready_q, wready_q, bvalid_q, arready_q, rvalid_q} <= 5'h00;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      wready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_idx == IDX_CONTROL || wr_idx == IDX_STATUS ||
                    wr_idx == IDX_DATA) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
      if (rd_go)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        case (rd_idx)
          IDX_CONTROL: rdata_q <= {24'h00_0000, ctrl_q};
          IDX_STATUS: rdata_q <= {24'h00_0000, rxf_q, ovr_q, 2'h0, txe_q, 1'b0, rate_q};
          IDX_DATA: rdata_q <= {24'h00_0000, rx_data_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign sclk_out = sclk_q;
  assign sclk_oe_n = sclk_oe_n_q;
  assign mosi_out = txsh_q[7];
  assign mosi_oe_n = mosi_oe_n_q;
  assign miso_out = txsh_q[7];
  assign miso_oe_n = miso_oe_n_q;
  assign irq_rx_full = irq_rx_q;
  assign irq_tx_empty = irq_tx_q;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  a_rx_full_set: assert property (done |=> rxf_q)
    else $error("rx full not set after byte");
  a_rx_copy: assert property (done && !rxf_q |=> rx_data_q == $past(rx_byte))
    else $error("received byte not copied");
  a_overrun_keep: assert property (done && rxf_q && !clr |=> ovr_q && $stable(rx_data_q))
    else $error("overrun did not keep old byte");
  a_rx_hold: assert property (rxf_q && !arm_q && !done |=> rxf_q)
    else $error("rx full cleared without status read");
  a_txie_clear: assert property (wr_dr |=> !ctrl_q[C_TXIE])
    else $error("data write left tx irq enable set");
  a_load_empty: assert property (load_now |=> txe_q && txsh_q == $past(wr_byte))
    else $error("idle write did not load shifter");
  a_master_start: assert property (m_start |=> state_q == SPIMS_RUN ##1 !sclk_oe_n)
    else $error("master did not start");
  a_fast_rate: assert property (m_tick && rate_q == 2'h0 && !done |=> m_tick)
    else $error("fastest rate is not bus over two");
  a_unsel_quiet: assert property (ss_f_q && !mstr |=> miso_oe_n)
    else $error("unselected slave drives miso");
  a_buf_wait: assert property (wr_dr && state_q == SPIMS_RUN && !done |=> !txe_q)
    else $error("busy write not buffered");

  c_master_byte: cover property (m_on && done);
  c_slave_byte: cover property (!mstr && done);
  c_overrun: cover property (done && rxf_q && !clr);
endmodule : spims_core

// [verification/spims_slave_model.sv]
module spims_slave_model (
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // bench control
  input wire logic load,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic [7:0] rx;
  int nb = 0;
  // ---------------------------------------------
  // mode 0 slave: sample on rise, shift on fall
  // ---------------------------------------------
  always @(posedge load)
  begin
    sh = tx_byte;
    miso = sh[7];
    nb = 0;
  end
  always @(posedge sclk)
  begin
    rx = {rx[6:0], mosi};
    nb = nb + 1;
  end
  always @(negedge sclk)
  begin
    if (nb == 8)
    begin
      rx_byte = rx;
      sh = tx_byte;
      nb = 0;
    end
    else
      sh = {sh[6:0], ~sh[7]};
    miso = sh[7];
  end
endmodule : spims_slave_model

// [verification/tb_top.sv]
module tb_top
  import spims_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sclk_in = 0, mosi_in = 0, ss_n_in = 1, p_load = 0, sclk_q = 0;
  logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_in, miso_out, miso_oe_n, irq_rx_full, irq_tx_empty;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] p_rx;
  logic [31:0] seed = 32'h41;
  int n_fail = 0;
  int comparisons = 0;
  spims_core i_spims_core (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk_in,
    .sclk_out, .sclk_oe_n, .mosi_in, .mosi_out, .mosi_oe_n, .miso_in, .miso_out, .miso_oe_n, .ss_n_in,
    .irq_rx_full, .irq_tx_empty);
  spims_slave_model i_spims_slave_model (.sclk(sclk_out), .mosi(mosi_out), .miso(miso_in), .load(p_load),
    .tx_byte(p_tx), .rx_byte(p_rx));
  initial
  begin
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) sclk_q <= sclk_out;
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic guard(inout int n);
    n++;
    if (n > 6000)
    begin
      $display("Error %0t: wait timed out", $time);
      n_fail++;
      tally_and_finish();
    end
  endtask : guard
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      n_fail++;
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
      n_fail++;
    end
  endtask : chk1
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    n = 0;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      guard(n);
      if (s_axi_awready)
      begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready)
      begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (!s_axi_bvalid)
    begin
      @(posedge aclk);
      guard(n);
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      guard(n);
    end
    while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid)
    begin
      @(posedge aclk);
      guard(n);
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : axi_rd
  task automatic poll_status(input int pos, output logic [7:0] d);
    int n;
    logic [1:0] r;
    n = 0;
    do
    begin
      axi_rd(IDX_STATUS, d, r);
      guard(n);
    end
    while (d[pos] !== 1'b1);
  endtask : poll_status
  task automatic load_partner(input logic [7:0] v);
    p_tx <= v;
    @(posedge aclk);
    p_load <= 1;
    @(posedge aclk);
    p_load <= 0;
  endtask : load_partner
  task automatic slave_frame(input logic ph, input logic [7:0] m, output logic [7:0] got);
    ss_n_in <= 0;
    mosi_in <= m[7];
    repeat (8) @(posedge aclk);
    chk1(miso_oe_n, 1'b0, "selected slave drive");
    for (int i = 7; i >= 0; i--)
    begin
      sclk_in <= 1;
      if (ph)
        mosi_in <= m[i];
      repeat (8) @(posedge aclk);
      got[i] = miso_out;
      sclk_in <= 0;
      if (!ph && i > 0)
        mosi_in <= m[i - 1];
      repeat (8) @(posedge aclk);
    end
    ss_n_in <= 1;
    repeat (8) @(posedge aclk);
    chk1(miso_oe_n, 1'b1, "deselected slave off");
  endtask : slave_frame
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    logic [7:0] d, a, x, y, s, m, got;
    logic [1:0] r;
    int n, per;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    load_partner(8'h00);
    axi_rd(IDX_CONTROL, d, r);
    chk8(d, CTRL_RST, "control reset");
    axi_rd(IDX_STATUS, d, r);
    chk8(d, 8'h08, "status reset");
    axi_rd(8'h13, d, r);
    chk8({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(8'h20, 8'h5a, r);
    chk8({6'h0, r}, {6'h0, RESP_SLVERR}, "unmapped write");
    axi_wr(IDX_CONTROL, 8'h23, r);
    for (int rt = 0; rt < 4; rt++)
    begin
      axi_wr(IDX_STATUS, 8'(rt), r);
      axi_wr(IDX_DATA, xs(), r);
      n = 0;
      do
      begin
        @(posedge aclk);
        guard(n);
      end
      while (!(sclk_out && !sclk_q));
      per = 0;
      do
      begin
        @(posedge aclk);
        per++;
        guard(n);
      end
      while (!(sclk_out && !sclk_q));
      chk8(8'(per), 8'(2 << (2 * rt)), "sclk period");
      poll_status(S_RXF, d);
      axi_rd(IDX_DATA, d, r);
    end
    axi_wr(IDX_STATUS, 8'h02, r);
    for (int k = 0; k < 3; k++)
    begin
      a = xs();
      x = xs();
      load_partner(a);
      axi_wr(IDX_CONTROL, 8'ha3, r);
      repeat (2) @(posedge aclk);
      chk1(irq_tx_empty, 1'b1, "tx empty irq");
      axi_wr(IDX_DATA, x, r);
      axi_rd(IDX_CONTROL, d, r);
      chk1(d[C_TXIE], 1'b0, "tx irq enable cleared");
      axi_rd(IDX_STATUS, d, r);
      chk1(d[S_TXE], 1'b1, "tx empty after load");
      chk1(irq_tx_empty, 1'b0, "tx irq off");
      chk1(sclk_oe_n, 1'b0, "master drives clock");
      chk1(mosi_oe_n, 1'b0, "master drives mosi");
      n = 0;
      while (irq_rx_full !== 1'b1)
      begin
        @(posedge aclk);
        guard(n);
      end
      axi_rd(IDX_DATA, d, r);
      chk8(d, a, "master rx byte");
      axi_rd(IDX_STATUS, d, r);
      chk1(d[S_RXF], 1'b1, "rx full kept");
      axi_rd(IDX_DATA, d, r);
      axi_rd(IDX_STATUS, d, r);
      chk1(d[S_RXF], 1'b0, "rx full cleared");
      chk1(irq_rx_full, 1'b0, "rx irq off");
      chk8(p_rx, x, "partner rx byte");
    end
    a = xs();
    x = xs();
    y = xs();
    load_partner(a);
    axi_wr(IDX_DATA, x, r);
    axi_wr(IDX_DATA, y, r);
    axi_rd(IDX_STATUS, d, r);
    chk1(d[S_TXE], 1'b0, "second byte buffered");
    p_tx <= xs();
    poll_status(S_OVR, d);
    axi_rd(IDX_DATA, d, r);
    chk8(d, a, "unread byte kept");
    chk8(p_rx, y, "buffered byte sent");
    axi_rd(IDX_STATUS, d, r);
    chk8(d, 8'h0a, "flags cleared");
    axi_wr(IDX_CONTROL, 8'h32, r);
    repeat (2) @(posedge aclk);
    chk1(sclk_out, 1'b1, "clock idles at polarity");
    axi_wr(IDX_CONTROL, 8'h00, r);
    axi_wr(IDX_CONTROL, 8'h02, r);
    s = xs();
    axi_wr(IDX_DATA, s, r);
    repeat (6) @(posedge aclk);
    chk1(miso_oe_n, 1'b1, "idle slave off");
    chk1(sclk_oe_n, 1'b1, "slave clock is input");
    chk1(mosi_oe_n, 1'b1, "slave mosi is input");
    for (int f = 0; f < 2; f++)
    begin
      m = xs();
      if (f == 1)
        axi_wr(IDX_CONTROL, 8'h0a, r);
      slave_frame(f == 1, m, got);
      chk8(got, s, "slave tx byte");
      poll_status(S_RXF, d);
      axi_rd(IDX_DATA, d, r);
      chk8(d, m, "slave rx byte");
    end
    tally_and_finish();
  end
endmodule : tb_top
